// ---- inc/pdpc_params.svh ----
// Constants for the port direction and pull-up control block: offsets, fields, resets
//
// Contract
// - 21 bidirectional port lines; 13 of them carry a software pull-up
// - each line has its own direction bit in its port's direction register
// - direction 0 turns the output driver on; 1 turns it off (a port-8 line with its function bit set is driven either way)
// - reset loads every direction register with all ones
// - group pull-up bits 0, 1 and 4 cover all lines of ports 0, 1, 4
// - port-2 pull-up register bits 0 to 2 cover one port-2 line each
// - pull-up applies only with enable set and line in input mode
// - a line driven by an alternate output never gets its pull-up
// - key-return mode register can also pull up port-4 lines
// - reset clears both pull-up registers and the port-8 function register
// - port-8 function bit 0 gives port line, 1 gives segment output
// - shared interrupt line level reaches interrupt logic even in output mode
// - every port control register takes single-bit and whole-byte writes
`ifndef PDPC_PARAMS_SVH
`define PDPC_PARAMS_SVH

// Register indices; byte address is four times the index
`define PDPC_IDX_DATA0   16'hFF00
`define PDPC_IDX_DATA1   16'hFF01
`define PDPC_IDX_DATA2   16'hFF02
`define PDPC_IDX_DATA4   16'hFF03
`define PDPC_IDX_DATA6   16'hFF05
`define PDPC_IDX_DATA8   16'hFF08
`define PDPC_IDX_DIR0    16'hFF20
`define PDPC_IDX_DIR1    16'hFF21
`define PDPC_IDX_DIR2    16'hFF22
`define PDPC_IDX_DIR4    16'hFF24
`define PDPC_IDX_DIR6    16'hFF26
`define PDPC_IDX_DIR8    16'hFF28
`define PDPC_IDX_PORT2_PULLUP_ENABLE    16'hFF32
`define PDPC_IDX_FUNC8   16'hFF58
`define PDPC_IDX_BITOP   16'hFF7E
`define PDPC_IDX_KRM     16'hFFF5
`define PDPC_IDX_PUG     16'hFFF7

// Implemented lines per port
`define PDPC_MASK_P0     8'h0F
`define PDPC_MASK_P1     8'h03
`define PDPC_MASK_P2     8'h07
`define PDPC_MASK_P4     8'h0F
`define PDPC_MASK_P6     8'h03
`define PDPC_MASK_P8     8'h3F
`define PDPC_MASK_PORT2_PULLUP_ENABLE   8'h07
`define PDPC_MASK_FUNC8  8'h3F
`define PDPC_MASK_PUG    8'h13

// Reset values
`define PDPC_DIR_RST     8'hFF
`define PDPC_CLR_RST     8'h00

// Field positions
`define PDPC_PUG_P0_BIT  0
`define PDPC_PUG_P1_BIT  1
`define PDPC_PUG_P4_BIT  4
`define PDPC_KRM_PU_BIT  0
`define PDPC_BITOP_VAL   19

// Line numbers of lines with alternate functions
`define PDPC_LINE_SCLK   6
`define PDPC_LINE_SDO    7
`define PDPC_LINE_TMR    13
`define PDPC_LINE_IRQ    14
`define PDPC_NLINES      21
`define PDPC_NPORTS      6

`endif

// ---- inc/pdpc_pkg.sv ----
// Types shared by the port direction and pull-up control block
package pdpc_pkg;

    typedef enum logic [2:0] {
        PDPC_REG_NONE  = 3'b000,
        PDPC_REG_DATA  = 3'b001,
        PDPC_REG_DIR   = 3'b010,
        PDPC_REG_PORT2_PULLUP_ENABLE  = 3'b011,
        PDPC_REG_FUNC8 = 3'b100,
        PDPC_REG_KRM   = 3'b101,
        PDPC_REG_PUG   = 3'b110,
        PDPC_REG_BITOP = 3'b111
    } pdpc_reg_type;

    typedef enum logic [1:0] {
        PDPC_ALT_NONE = 2'b00,
        PDPC_ALT_AND  = 2'b01,
        PDPC_ALT_OR   = 2'b10,
        PDPC_ALT_SEG  = 2'b11
    } pdpc_alt_type;

    typedef struct packed {
        logic [2:0]   port;
        pdpc_reg_type kind;
    } pdpc_sel_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [17:0] paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } pdpc_apb_req_type;

    typedef struct packed {
        logic       sclk_act;
        logic       sclk_val;
        logic       sdo_act;
        logic       sdo_val;
        logic       tmr_act;
        logic       tmr_val;
        logic [5:0] seg;
    } pdpc_alt_out_type;

    typedef struct packed {
        logic         dir;
        logic         latch;
        logic         pull_req;
        logic         alt_act;
        pdpc_alt_type alt_kind;
        logic         alt_val;
    } pdpc_line_ctrl_type;

    // First line number of each port ordinal (ports 0, 1, 2, 4, 6, 8)
    function automatic int pdpc_line_base(input int port);
        case (port)
            0:       return 0;
            1:       return 4;
            2:       return 6;
            3:       return 9;
            4:       return 13;
            default: return 15;
        endcase
    endfunction

    function automatic int pdpc_line_port(input int line);
        int p;
        p = 0;
        for (int k = 1; k < 6; k++) begin
            if (line >= pdpc_line_base(k)) begin
                p = k;
            end
        end
        return p;
    endfunction

endpackage

// ---- hw/pdpc_line_cell.sv ----
// One port line: pin synchroniser, output driver, enable and pull-up control
`timescale 1ns/100ps
`default_nettype none
`include "pdpc_params.svh"

module pdpc_line_cell
    import pdpc_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               reset,
    input  wire pdpc_line_ctrl_type ctrl,
    input  wire logic               pin_in,
    output logic                    pin_out,
    output logic                    pin_oe,
    output logic                    pullup_en,
    output logic                    pin_level
);

    logic sync1_r;
    logic out_nxt;
    logic oe_nxt;
    logic pull_nxt;

    // Two-stage synchroniser; only the second stage is seen by logic
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sync1_r   <= 1'b0;
            pin_level <= 1'b0;
        end else begin
            sync1_r   <= pin_in;
            pin_level <= sync1_r;
        end
    end

    // Driver level: serial outputs gate with latch 1, timer ORs with latch 0
    always_comb begin
        unique case (ctrl.alt_kind)
            PDPC_ALT_AND:  out_nxt = ctrl.latch & (ctrl.alt_val | ~ctrl.alt_act);
            PDPC_ALT_OR:   out_nxt = ctrl.latch | (ctrl.alt_val & ctrl.alt_act);
            PDPC_ALT_SEG:  out_nxt = ctrl.alt_val;
            PDPC_ALT_NONE: out_nxt = ctrl.latch;
        endcase
        // Segment mode drives regardless of direction
        oe_nxt   = (ctrl.alt_kind == PDPC_ALT_SEG) | ~ctrl.dir;
        // Pull-up only on an input line that no alternate output drives
        pull_nxt = ctrl.pull_req & ctrl.dir & ~ctrl.alt_act;
    end

    // Registered pad controls
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pin_out   <= 1'b0;
            pin_oe    <= 1'b0;
            pullup_en <= 1'b0;
        end else begin
            pin_out   <= out_nxt;
            pin_oe    <= oe_nxt;
            pullup_en <= pull_nxt;
        end
    end

    a_out_pull_off: assert property (@(posedge ref_clk) disable iff (reset)
        !ctrl.dir |=> !pullup_en) else $error("pull-up on an output line");

    a_alt_pull_off: assert property (@(posedge ref_clk) disable iff (reset)
        ctrl.alt_act |=> !pullup_en) else $error("pull-up under alternate output");

    a_dir_drives_oe: assert property (@(posedge ref_clk) disable iff (reset)
        (ctrl.alt_kind != PDPC_ALT_SEG) |=> (pin_oe == !$past(ctrl.dir)))
        else $error("driver enable does not follow direction");

    a_seg_drive: assert property (@(posedge ref_clk) disable iff (reset)
        (ctrl.alt_kind == PDPC_ALT_SEG) |=> (pin_oe && pin_out == $past(ctrl.alt_val)))
        else $error("segment line not driven by segment signal");

endmodule

`default_nettype wire

// ---- hw/pdpc_top.sv ----
// Port direction, pull-up and port-8 function registers behind an APB slave
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "pdpc_params.svh"

module pdpc_top
    import pdpc_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire pdpc_apb_req_type apb_req,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire pdpc_alt_out_type alt_out,
    input  wire logic [20:0]      pin_in,
    output logic [20:0]           pin_out,
    output logic [20:0]           pin_oe,
    output logic [20:0]           pullup_en,
    output logic [20:0]           pin_level,
    output logic                  shared_irq_level
);

    ////////////////////////////////////////////////////////////////////////////
    // Storage

    logic [7:0]   dir_r   [0:5];
    logic [7:0]   latch_r [0:5];
    logic [7:0]   port2_pullup_enable_r;
    logic [7:0]   func8_r;
    logic [7:0]   krm_r;
    logic [7:0]   pug_r;
    logic         pready_r;
    logic         pslverr_r;
    logic [31:0]  prdata_r;
    logic         irq_r;
    logic [20:0]  line_rd;
    logic [7:0]   data_view [0:5];
    pdpc_sel_type sel;
    pdpc_sel_type tgt;
    pdpc_sel_type wr_sel;
    logic         wr_en;
    logic [7:0]   wr_val;
    logic         acc;
    logic         setup;
    logic [7:0]   sel_mask;

    assign prdata           = prdata_r;
    assign pready           = pready_r;
    assign pslverr          = pslverr_r;
    assign shared_irq_level = irq_r;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Implemented lines of a port ordinal
    function automatic logic [7:0] port_mask(input logic [2:0] p);
        case (p)
            3'h0:    return `PDPC_MASK_P0;
            3'h1:    return `PDPC_MASK_P1;
            3'h2:    return `PDPC_MASK_P2;
            3'h3:    return `PDPC_MASK_P4;
            3'h4:    return `PDPC_MASK_P6;
            default: return `PDPC_MASK_P8;
        endcase
    endfunction

    // Register index to register kind and port ordinal
    function automatic pdpc_sel_type decode(input logic [15:0] idx);
        pdpc_sel_type s;
        s.port = 3'h0;
        s.kind = PDPC_REG_NONE;
        case (idx)
            `PDPC_IDX_DATA0: begin s.port = 3'h0; s.kind = PDPC_REG_DATA; end
            `PDPC_IDX_DATA1: begin s.port = 3'h1; s.kind = PDPC_REG_DATA; end
            `PDPC_IDX_DATA2: begin s.port = 3'h2; s.kind = PDPC_REG_DATA; end
            `PDPC_IDX_DATA4: begin s.port = 3'h3; s.kind = PDPC_REG_DATA; end
            `PDPC_IDX_DATA6: begin s.port = 3'h4; s.kind = PDPC_REG_DATA; end
            `PDPC_IDX_DATA8: begin s.port = 3'h5; s.kind = PDPC_REG_DATA; end
            `PDPC_IDX_DIR0:  begin s.port = 3'h0; s.kind = PDPC_REG_DIR; end
            `PDPC_IDX_DIR1:  begin s.port = 3'h1; s.kind = PDPC_REG_DIR; end
            `PDPC_IDX_DIR2:  begin s.port = 3'h2; s.kind = PDPC_REG_DIR; end
            `PDPC_IDX_DIR4:  begin s.port = 3'h3; s.kind = PDPC_REG_DIR; end
            `PDPC_IDX_DIR6:  begin s.port = 3'h4; s.kind = PDPC_REG_DIR; end
            `PDPC_IDX_DIR8:  begin s.port = 3'h5; s.kind = PDPC_REG_DIR; end
            `PDPC_IDX_PORT2_PULLUP_ENABLE:  s.kind = PDPC_REG_PORT2_PULLUP_ENABLE;
            `PDPC_IDX_FUNC8: s.kind = PDPC_REG_FUNC8;
            `PDPC_IDX_KRM:   s.kind = PDPC_REG_KRM;
            `PDPC_IDX_PUG:   s.kind = PDPC_REG_PUG;
            `PDPC_IDX_BITOP: s.kind = PDPC_REG_BITOP;
            default:         s.kind = PDPC_REG_NONE;
        endcase
        return s;
    endfunction

    // Current contents of a register as software sees them
    function automatic logic [7:0] read_reg(input pdpc_sel_type s);
        logic [7:0] v;
        v = 8'h00;
        case (s.kind)
            PDPC_REG_DATA:  v = data_view[s.port];
            PDPC_REG_DIR:   v = dir_r[s.port];
            PDPC_REG_PORT2_PULLUP_ENABLE:  v = port2_pullup_enable_r;
            PDPC_REG_FUNC8: v = func8_r;
            PDPC_REG_KRM:   v = krm_r;
            PDPC_REG_PUG:   v = pug_r;
            default:        v = 8'h00;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // APB decode and write path

    // Bit access goes through a helper register as a read-modify-write, so
    // input lines of a port register take the pin level, as a CPU bit op does
    always_comb begin
        setup    = apb_req.psel & ~apb_req.penable;
        acc      = apb_req.psel & apb_req.penable & pready_r;
        sel      = decode(apb_req.paddr[17:2]);
        tgt      = decode(apb_req.pwdata[15:0]);
        sel_mask = port_mask(sel.port);
        wr_en    = 1'b0;
        wr_sel   = sel;
        wr_val   = apb_req.pwdata[7:0];
        if (acc && apb_req.pwrite && apb_req.pstrb[0]) begin
            if (sel.kind == PDPC_REG_BITOP) begin
                if (tgt.kind != PDPC_REG_NONE && tgt.kind != PDPC_REG_BITOP) begin
                    wr_en  = 1'b1;
                    wr_sel = tgt;
                    wr_val = read_reg(tgt);
                    wr_val[apb_req.pwdata[18:16]] = apb_req.pwdata[`PDPC_BITOP_VAL];
                end
            end else if (sel.kind != PDPC_REG_NONE) begin
                wr_en = 1'b1;
            end
        end
    end

    // Answer one cycle after setup; data and error are caught at setup
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup & (sel.kind == PDPC_REG_NONE);
            if (setup) begin
                prdata_r <= {24'h00_0000, read_reg(sel)};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers

    // Direction bits per line; unused positions held at one
    always_ff @(posedge ref_clk) begin
        for (int p = 0; p < `PDPC_NPORTS; p++) begin
            if (reset) begin
                dir_r[p] <= `PDPC_DIR_RST;
            end else if (wr_en && wr_sel.kind == PDPC_REG_DIR && wr_sel.port == p[2:0]) begin
                dir_r[p] <= wr_val | ~port_mask(p[2:0]);
            end
        end
    end

    // Output latches take writes whatever the direction
    always_ff @(posedge ref_clk) begin
        for (int p = 0; p < `PDPC_NPORTS; p++) begin
            if (reset) begin
                latch_r[p] <= `PDPC_CLR_RST;
            end else if (wr_en && wr_sel.kind == PDPC_REG_DATA && wr_sel.port == p[2:0]) begin
                latch_r[p] <= wr_val & port_mask(p[2:0]);
            end
        end
    end

    // Pull-up and function registers; unimplemented bits are not stored, except in krm_r, which keeps all eight
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            port2_pullup_enable_r  <= `PDPC_CLR_RST;
            pug_r   <= `PDPC_CLR_RST;
            func8_r <= `PDPC_CLR_RST;
            krm_r   <= `PDPC_CLR_RST;
        end else if (wr_en) begin
            if (wr_sel.kind == PDPC_REG_PORT2_PULLUP_ENABLE) begin
                port2_pullup_enable_r <= wr_val & `PDPC_MASK_PORT2_PULLUP_ENABLE;
            end
            if (wr_sel.kind == PDPC_REG_PUG) begin
                pug_r <= wr_val & `PDPC_MASK_PUG;
            end
            if (wr_sel.kind == PDPC_REG_FUNC8) begin
                func8_r <= wr_val & `PDPC_MASK_FUNC8;
            end
            if (wr_sel.kind == PDPC_REG_KRM) begin
                krm_r <= wr_val;
            end
        end
    end

    // Shared interrupt line keeps feeding the interrupt logic in output mode
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= pin_level[`PDPC_LINE_IRQ];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-line control

    // Port read view: latch for output lines, pin for input lines
    always_comb begin
        for (int p = 0; p < `PDPC_NPORTS; p++) begin
            data_view[p] = 8'h00;
            for (int b = 0; b < 8; b++) begin
                if (((port_mask(p[2:0]) >> b) & 8'h01) != 8'h00) begin
                    data_view[p][b] = line_rd[pdpc_line_base(p) + b];
                end
            end
        end
    end

    for (genvar i = 0; i < `PDPC_NLINES; i++) begin : g_line
        localparam int P = pdpc_line_port(i);
        localparam int B = i - pdpc_line_base(P);
        pdpc_line_ctrl_type ctrl;

        always_comb begin
            ctrl.dir      = dir_r[P][B];
            ctrl.latch    = latch_r[P][B];
            ctrl.alt_act  = 1'b0;
            ctrl.alt_kind = PDPC_ALT_NONE;
            ctrl.alt_val  = 1'b0;
            // Thirteen lines can be pulled up: ports 0, 1, 2 and 4
            if (P == 0) begin
                ctrl.pull_req = pug_r[`PDPC_PUG_P0_BIT];
            end else if (P == 1) begin
                ctrl.pull_req = pug_r[`PDPC_PUG_P1_BIT];
            end else if (P == 2) begin
                ctrl.pull_req = port2_pullup_enable_r[B];
            end else if (P == 3) begin
                ctrl.pull_req = pug_r[`PDPC_PUG_P4_BIT] | krm_r[`PDPC_KRM_PU_BIT];
            end else begin
                ctrl.pull_req = 1'b0;
            end
            // Alternate outputs that take over a line
            if (i == `PDPC_LINE_SCLK) begin
                ctrl.alt_act  = alt_out.sclk_act;
                ctrl.alt_kind = PDPC_ALT_AND;
                ctrl.alt_val  = alt_out.sclk_val;
            end else if (i == `PDPC_LINE_SDO) begin
                ctrl.alt_act  = alt_out.sdo_act;
                ctrl.alt_kind = PDPC_ALT_AND;
                ctrl.alt_val  = alt_out.sdo_val;
            end else if (i == `PDPC_LINE_TMR) begin
                ctrl.alt_act  = alt_out.tmr_act;
                ctrl.alt_kind = PDPC_ALT_OR;
                ctrl.alt_val  = alt_out.tmr_val;
            end else if (P == 5) begin
                ctrl.alt_act  = func8_r[B];
                ctrl.alt_kind = func8_r[B] ? PDPC_ALT_SEG : PDPC_ALT_NONE;
                ctrl.alt_val  = alt_out.seg[B];
            end
        end

        // Continuous per-bit drive keeps one driver per bit of the read view
        assign line_rd[i] = dir_r[P][B] ? pin_level[i] : latch_r[P][B];

        pdpc_line_cell u_cell (
            .ref_clk   (ref_clk),
            .reset     (reset),
            .ctrl      (ctrl),
            .pin_in    (pin_in[i]),
            .pin_out   (pin_out[i]),
            .pin_oe    (pin_oe[i]),
            .pullup_en (pullup_en[i]),
            .pin_level (pin_level[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    a_dir_reset_ones: assert property (@(posedge ref_clk) disable iff (reset)
        $past(reset) |-> (dir_r[0] == 8'hFF && dir_r[1] == 8'hFF && dir_r[2] == 8'hFF
                          && dir_r[3] == 8'hFF && dir_r[4] == 8'hFF && dir_r[5] == 8'hFF))
        else $error("direction register not all ones after reset");

    a_pull_reset_zero: assert property (@(posedge ref_clk) disable iff (reset)
        $past(reset) |-> (port2_pullup_enable_r == 8'h00 && pug_r == 8'h00 && func8_r == 8'h00))
        else $error("pull-up or function register not cleared by reset");

    a_unimpl_read_ones: assert property (@(posedge ref_clk) disable iff (reset)
        (setup && !apb_req.pwrite && sel.kind == PDPC_REG_DIR)
        |=> (pready && (prdata[7:0] | $past(sel_mask)) == 8'hFF && prdata[31:8] == 24'h0))
        else $error("unimplemented direction bits do not read as one");

    a_byte_write_lands: assert property (@(posedge ref_clk) disable iff (reset)
        (acc && apb_req.pwrite && apb_req.pstrb[0] && sel.kind == PDPC_REG_PORT2_PULLUP_ENABLE)
        |=> port2_pullup_enable_r == ($past(apb_req.pwdata[7:0]) & 8'h07))
        else $error("byte write to port-2 pull-up register lost");

    a_no_strobe_hold: assert property (@(posedge ref_clk) disable iff (reset)
        (acc && apb_req.pwrite && !apb_req.pstrb[0] && sel.kind == PDPC_REG_PUG)
        |=> $stable(pug_r))
        else $error("write without lane strobe changed a register");

    a_irq_level_follows: assert property (@(posedge ref_clk) disable iff (reset)
        (!$past(reset) && !$past(reset, 2) && !$past(reset, 3))
        |-> shared_irq_level == $past(pin_in[`PDPC_LINE_IRQ], 3))
        else $error("shared interrupt level does not follow the pin");

endmodule

`default_nettype wire

// ---- verification/pdpc_pad_model.sv ----
// Board-side pad model: resolves each port line from device, board and pull-up
`timescale 1ns/100ps
`default_nettype none

module pdpc_pad_model (
    input  wire logic        ref_clk,
    input  wire logic [20:0] pin_out,
    input  wire logic [20:0] pin_oe,
    input  wire logic [20:0] pullup_en,
    input  wire logic [20:0] ext_oe,
    input  wire logic [20:0] ext_val,
    output logic      [20:0] pin_in
);
    logic [20:0] float_r = 21'h0A5A5;

    // An undriven line wanders, so a stale level is never mistaken for data
    always @(posedge ref_clk) begin
        float_r <= ~float_r;
    end

    // Device driver wins, then the board, then the pull-up
    assign pin_in = (pin_oe & pin_out)
                  | (~pin_oe & ext_oe & ext_val)
                  | (~pin_oe & ~ext_oe & pullup_en)
                  | (~pin_oe & ~ext_oe & ~pullup_en & float_r);
endmodule
`default_nettype wire

// ---- verification/pdpc_top_test.sv ----
// Self-checking bench for the port direction and pull-up control block
`timescale 1ns/100ps
`default_nettype none
`include "pdpc_params.svh"

module pdpc_top_test
    import pdpc_pkg::*;
;
    logic             ref_clk = 1'b0;
    logic             reset   = 1'b1;
    pdpc_apb_req_type req     = '0;
    pdpc_alt_out_type alt     = '0;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             shared_irq_level;
    logic [20:0]      pin_in;
    logic [20:0]      pin_out;
    logic [20:0]      pin_oe;
    logic [20:0]      pullup_en;
    logic [20:0]      pin_level;
    logic [20:0]      ext_oe  = 21'h0;
    logic [20:0]      ext_val = 21'h0;
    logic [7:0]       rd;
    logic             er;
    logic [31:0]      r;
    logic [20:0]      en;
    logic [20:0]      dl;
    logic [7:0]       pug, port2_pullup_enable, krm, f8;
    logic [7:0]       dir   [6];
    logic [7:0]       cval  [4];
    logic [7:0]       dmask [6] = '{`PDPC_MASK_P0, `PDPC_MASK_P1, `PDPC_MASK_P2,
                                    `PDPC_MASK_P4, `PDPC_MASK_P6, `PDPC_MASK_P8};
    logic [15:0]      ridx  [10] = '{`PDPC_IDX_DIR0, `PDPC_IDX_DIR1, `PDPC_IDX_DIR2,
                                     `PDPC_IDX_DIR4, `PDPC_IDX_DIR6, `PDPC_IDX_DIR8,
                                     `PDPC_IDX_PUG, `PDPC_IDX_PORT2_PULLUP_ENABLE, `PDPC_IDX_KRM,
                                     `PDPC_IDX_FUNC8};
    integer           seed = 32'hBCA7;
    int               err_count = 0;
    int               comparisons = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    pdpc_top i_dut (
        .ref_clk          (ref_clk),
        .reset            (reset),
        .apb_req          (req),
        .prdata           (prdata),
        .pready           (pready),
        .pslverr          (pslverr),
        .alt_out          (alt),
        .pin_in           (pin_in),
        .pin_out          (pin_out),
        .pin_oe           (pin_oe),
        .pullup_en        (pullup_en),
        .pin_level        (pin_level),
        .shared_irq_level (shared_irq_level)
    );

    pdpc_pad_model i_pads (
        .ref_clk   (ref_clk),
        .pin_out   (pin_out),
        .pin_oe    (pin_oe),
        .pullup_en (pullup_en),
        .ext_oe    (ext_oe),
        .ext_val   (ext_val),
        .pin_in    (pin_in)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Comparisons and verdict
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t register %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [20:0] got, input logic [20:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t lines %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results;
        if (err_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One APB transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] d,
                       input logic [3:0] st);
        int n;
        n = 0;
        @(posedge ref_clk);
        req <= '{1'b1, 1'b0, wr, {idx, 2'h0}, d, st};
        @(posedge ref_clk);
        req.penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40) err_count++;
        rd = prdata[7:0];
        er = pslverr;
        req <= '0;
    endtask

    // Pad outputs and synchronised levels need a few edges to follow
    task automatic settle;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask

    // Direction bits in line order; 1 means input
    function automatic logic [20:0] dir_lines();
        return {dir[5][5:0], dir[4][1:0], dir[3][3:0], dir[2][2:0], dir[1][1:0], dir[0][3:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            apb(1'b0, ridx[i], 32'h0, 4'h0);
            chk_reg(rd, (i < 6) ? 8'hFF : 8'h00);
        end
        // Port read mixes latch on outputs with pin level on inputs
        r = $random(seed);
        ext_oe <= 21'h1FFFFF;
        ext_val <= r[20:0];
        apb(1'b1, `PDPC_IDX_DATA0, 32'h05, 4'hF);
        apb(1'b1, `PDPC_IDX_DIR0, 32'h0A, 4'hF);
        settle;
        apb(1'b0, `PDPC_IDX_DATA0, 32'h0, 4'h0);
        chk_reg(rd & 8'h0F, {4'h0, 4'h5 | (ext_val[3:0] & 4'hA)});
        // Random settings; first pass makes every line an output, second hands port 8 over
        for (int i = 0; i < 6; i++) begin
            for (int p = 0; p < 6; p++) begin
                r = $random(seed);
                dir[p] = (i == 0) ? 8'h00 : r[7:0];
                apb(1'b1, ridx[p], {24'h0, dir[p]}, 4'hF);
                apb(1'b0, ridx[p], 32'h0, 4'h0);
                chk_reg(rd, dir[p] | ~dmask[p]);
            end
            r = $random(seed);
            pug = r[7:0] & 8'h13;
            port2_pullup_enable = r[15:8] & 8'h07;
            krm = {7'h0, r[16]};
            f8 = (i == 1) ? 8'h3F : (r[31:24] & 8'h3F);
            cval = '{pug, port2_pullup_enable, krm, f8};
            r = $random(seed);
            alt <= r[11:0];
            for (int k = 0; k < 4; k++) begin
                apb(1'b1, ridx[6 + k], {24'h0, cval[k]}, 4'hF);
                apb(1'b0, ridx[6 + k], 32'h0, 4'h0);
                chk_reg(rd, cval[k]);
            end
            settle;
            dl = dir_lines();
            en = {8'h0, {4{pug[4] | krm[0]}}, port2_pullup_enable[2:0], {2{pug[1]}}, {4{pug[0]}}};
            en[6] &= ~alt.sclk_act;
            en[7] &= ~alt.sdo_act;
            chk_pin(pullup_en, en & dl);
            chk_pin(pin_oe, ~dl | {f8[5:0], 15'h0});
            chk_pin(pin_out & {f8[5:0], 15'h0}, {alt.seg & f8[5:0], 15'h0});
            chk_pin(pin_out & 21'h020C0, {7'h0, alt.tmr_val & alt.tmr_act, 13'h0});
            chk_pin(pin_level, pin_in);
        end
        // Unmapped index, write without strobe, then a single-bit clear
        apb(1'b0, 16'hFF30, 32'h0, 4'h0);
        chk_reg({er, rd[6:0]}, 8'h80);
        apb(1'b1, `PDPC_IDX_DIR0, 32'h0, 4'h0);
        apb(1'b1, `PDPC_IDX_PUG, 32'hFF, 4'h0);
        apb(1'b0, `PDPC_IDX_PUG, 32'h0, 4'h0);
        chk_reg(rd, pug);
        apb(1'b1, `PDPC_IDX_BITOP, {12'h0, 1'h0, 3'h3, `PDPC_IDX_DIR0}, 4'hF);
        apb(1'b0, `PDPC_IDX_DIR0, 32'h0, 4'h0);
        chk_reg(rd, (dir[0] | 8'hF0) & 8'hF7);
        // Shared interrupt line keeps reporting its level in output mode
        apb(1'b1, `PDPC_IDX_DIR6, 32'hFD, 4'hF); // (interrupt logic lies outside)
        for (int v = 0; v < 2; v++) begin
            apb(1'b1, `PDPC_IDX_DATA6, {30'h0, v[0], 1'h0}, 4'hF);
            settle;
            chk_reg({7'h0, shared_irq_level}, {7'h0, v[0]});
        end
        results;
    end

    // Watchdog well beyond the expected run length
    initial begin
        #200000;
        err_count++;
        results;
    end
endmodule
`default_nettype wire
